// File: pkg/edq_defines.svh
// constants for the descriptor queue host controller
`ifndef EDQ_DEFINES_SVH
`define EDQ_DEFINES_SVH
`define EDQ_OFF_CMD 8'h00
`define EDQ_OFF_ADDR 8'h04
`define EDQ_OFF_NEXT 8'h08
`define EDQ_OFF_BUF 8'h0C
`define EDQ_OFF_OFFLEN 8'h10
`define EDQ_OFF_FLGLEN 8'h14
`define EDQ_OFF_STATUS 8'h18
`define EDQ_OFF_ENABLE 8'h1C
`define EDQ_OFF_ACTIVE 8'h20
`define EDQ_OFF_RESTART 8'h24
`define EDQ_WORD_FLGLEN 32'h0000000C
`define EDQ_FLG_FIRST 31
`define EDQ_FLG_LAST 30
`define EDQ_FLG_ENGINE_OWNS_FLAG 29
`define EDQ_FLG_QEND 28
`define EDQ_FLG_TDONE 27
`define EDQ_FLG_KCRC 26
`define EDQ_ST_BUSY 0
`define EDQ_ST_INIT 1
`define EDQ_ST_ERR 2
`define EDQ_NUM_QUEUES 16
`define EDQ_INIT_LAST 4'hF
`endif

// File: pkg/edq_pkg.sv
// types for the descriptor queue host controller
package edq_pkg;
  typedef enum logic [2:0] {
    EDQ_OP_NONE,
    EDQ_OP_BUILD,
    EDQ_OP_START,
    EDQ_OP_APPEND,
    EDQ_OP_POLL
  } edq_op_t;
  typedef enum {
    EDQ_S_INIT,
    EDQ_S_IDLE,
    EDQ_S_BUILD,
    EDQ_S_START,
    EDQ_S_APPEND,
    EDQ_S_POLL,
    EDQ_S_POLLCHK
  } edq_state_t;
  typedef struct packed {
    logic rx;
    logic [2:0] ch;
    logic [31:0] ptr;
  } edq_hdp_t;
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } edq_mreq_t;
endpackage : edq_pkg

// File: rtl/edq_mem_xfer.sv
// single word memory access sequencer
`include "edq_defines.svh"
module edq_mem_xfer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input edq_pkg::edq_mreq_t req,
  output logic mem_valid,
  output edq_pkg::edq_mreq_t mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic done,
  output logic [31:0] rdata
);
  import edq_pkg::*;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem_out <= '0;
      done <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (mem_valid && mem_ack) begin
        mem_valid <= 1'b0;
        done <= 1'b1;
        rdata <= mem_rdata;
      end else if (start && !mem_valid && !done) begin
        mem_valid <= 1'b1;
        mem_out <= req;
      end
    end
  end
  // request held until acknowledged
  a_mem_hold: assert property (@(posedge clk) disable iff (!rst_n)
    mem_valid && !mem_ack |=> mem_valid && $stable(mem_out))
    else $error("memory request dropped or changed before ack");
endmodule : edq_mem_xfer

// File: rtl/edq_hdp_if.sv
// head pointer write port and per queue activity tracking
`include "edq_defines.svh"
module edq_hdp_if (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_in,
  input edq_pkg::edq_hdp_t req,
  input wire logic clr,
  input wire logic [3:0] clr_idx,
  output logic hdp_wr,
  output edq_pkg::edq_hdp_t hdp,
  output logic [15:0] active
);
  import edq_pkg::*;
  logic [3:0] wr_idx;
  assign wr_idx = {req.rx, req.ch};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdp_wr <= 1'b0;
      hdp <= '0;
    end else begin
      hdp_wr <= wr_in;
      if (wr_in) begin
        hdp <= req;
      end
    end
  end
  // queue end returns channel to idle unless a nonzero head pointer write to it lands in the same cycle
  genvar g;
  generate
    for (g = 0; g < `EDQ_NUM_QUEUES; g++) begin : g_act
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          active[g] <= 1'b0;
        end else if (wr_in && wr_idx == g && req.ptr != 32'h00000000) begin
          active[g] <= 1'b1;
        end else if (clr && clr_idx == g) begin
          active[g] <= 1'b0;
        end
      end
    end
  endgenerate
  a_no_rewrite: assert property (@(posedge clk) disable iff (!rst_n)
    wr_in && req.ptr != 32'h00000000 |-> !active[wr_idx] || (clr && clr_idx == wr_idx))
    else $error("head pointer rewritten on active queue");
endmodule : edq_hdp_if

// File: rtl/edq_host.sv
// descriptor queue host controller with apb command registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "edq_defines.svh"
module edq_host #(
  parameter int CHANNELS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_valid,
  output edq_pkg::edq_mreq_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic hdp_wr,
  output edq_pkg::edq_hdp_t hdp,
  output logic tx_enable,
  output logic rx_enable
);
  import edq_pkg::*;

  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8");
  end

  edq_state_t state;
  edq_state_t next_state;
  logic [3:0] init_cnt;
  logic init_done;
  logic [1:0] word;
  logic [31:0] desc_addr;
  logic [31:0] next_ptr;
  logic [31:0] buf_ptr;
  logic [31:0] off_len;
  logic [31:0] flg_len;
  logic [31:0] restart_ptr;
  logic [15:0] last_flags;
  logic [2:0] cmd_op;
  logic cmd_rx;
  logic [2:0] cmd_ch;
  logic cmd_go;
  logic err;
  logic err_set;
  logic restart_take;
  logic mx_start;
  logic mx_done;
  logic [31:0] mx_rdata;
  edq_mreq_t mreq;
  logic hdp_wr_in;
  edq_hdp_t hdp_req;
  logic clr;
  logic [15:0] active;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic [31:0] words [4];

  function automatic logic misaligned(input logic [31:0] a);
    misaligned = (a[1:0] != 2'b00);
  endfunction : misaligned

  function automatic logic ch_bad(input logic [2:0] ch);
    ch_bad = ({29'h0, ch} >= 32'(CHANNELS));
  endfunction : ch_bad

  assign words[0] = next_ptr;
  assign words[1] = buf_ptr;
  assign words[2] = off_len;
  assign words[3] = flg_len;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign cmd_go = apb_wr && paddr == `EDQ_OFF_CMD && state == EDQ_S_IDLE;

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h00000000;
    case (paddr)
      `EDQ_OFF_CMD: prdata = {25'h0, cmd_ch, cmd_rx, cmd_op};
      `EDQ_OFF_ADDR: prdata = desc_addr;
      `EDQ_OFF_NEXT: prdata = next_ptr;
      `EDQ_OFF_BUF: prdata = buf_ptr;
      `EDQ_OFF_OFFLEN: prdata = off_len;
      `EDQ_OFF_FLGLEN: prdata = flg_len;
      `EDQ_OFF_STATUS: prdata = {last_flags, 13'h0, err, init_done, state != EDQ_S_IDLE};
      `EDQ_OFF_ENABLE: prdata = {30'h0, rx_enable, tx_enable};
      `EDQ_OFF_ACTIVE: prdata = {16'h0, active};
      `EDQ_OFF_RESTART: prdata = restart_ptr;
      default: mapped = 1'b0;
    endcase
    if (!apb_rd) begin
      prdata = 32'h00000000;
    end
  end

  // command and descriptor field registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_op <= 3'h0;
      cmd_rx <= 1'b0;
      cmd_ch <= 3'h0;
      desc_addr <= 32'h00000000;
      next_ptr <= 32'h00000000;
      buf_ptr <= 32'h00000000;
      off_len <= 32'h00000000;
      flg_len <= 32'h00000000;
    end else if (apb_wr && state == EDQ_S_IDLE) begin
      case (paddr)
        `EDQ_OFF_CMD: begin
          cmd_op <= pwdata[2:0];
          cmd_rx <= pwdata[3];
          cmd_ch <= pwdata[6:4];
        end
        `EDQ_OFF_ADDR: desc_addr <= pwdata;
        `EDQ_OFF_NEXT: next_ptr <= pwdata;
        `EDQ_OFF_BUF: buf_ptr <= pwdata;
        `EDQ_OFF_OFFLEN: off_len <= pwdata;
        `EDQ_OFF_FLGLEN: flg_len <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // error flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else if (err_set || (apb_wr && paddr == `EDQ_OFF_CMD && state != EDQ_S_IDLE)) begin
      err <= 1'b1;
    end else if (apb_wr && paddr == `EDQ_OFF_STATUS && pwdata[`EDQ_ST_ERR]) begin
      err <= 1'b0;
    end
  end

  // pending restart pointer consumed on queue end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_ptr <= 32'h00000000;
    end else if (restart_take) begin
      restart_ptr <= 32'h00000000;
    end else if (apb_wr && paddr == `EDQ_OFF_RESTART) begin
      restart_ptr <= pwdata;
    end
  end

  // enables held off until head pointers cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
    end else if (apb_wr && paddr == `EDQ_OFF_ENABLE && init_done) begin
      tx_enable <= pwdata[0];
      rx_enable <= pwdata[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= 4'h0;
      init_done <= 1'b0;
    end else if (state == EDQ_S_INIT) begin
      init_cnt <= init_cnt + 4'h1;
      init_done <= (init_cnt == `EDQ_INIT_LAST);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word <= 2'h0;
    end else if (state != EDQ_S_BUILD) begin
      word <= 2'h0;
    end else if (mx_done) begin
      word <= word + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_flags <= 16'h0000;
    end else if (state == EDQ_S_POLLCHK) begin
      last_flags <= mx_rdata[31:16];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EDQ_S_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    err_set = 1'b0;
    mx_start = 1'b0;
    mreq = '0;
    hdp_wr_in = 1'b0;
    hdp_req = '0;
    clr = 1'b0;
    restart_take = 1'b0;
    case (state)
      EDQ_S_INIT: begin
        // zero every head pointer after reset
        hdp_wr_in = 1'b1;
        hdp_req = {init_cnt[3], init_cnt[2:0], 32'h00000000};
        if (init_cnt == `EDQ_INIT_LAST) begin
          next_state = EDQ_S_IDLE;
        end
      end
      EDQ_S_IDLE: begin
        if (cmd_go) begin
          case (pwdata[2:0])
            EDQ_OP_BUILD: begin
              if (misaligned(desc_addr) || misaligned(next_ptr)) begin
                err_set = 1'b1;
              end else if (flg_len[`EDQ_FLG_ENGINE_OWNS_FLAG] && !flg_len[`EDQ_FLG_FIRST]) begin
                err_set = 1'b1;
              end else begin
                next_state = EDQ_S_BUILD;
              end
            end
            EDQ_OP_START: begin
              if (misaligned(desc_addr) || ch_bad(pwdata[6:4]) || active[{pwdata[3], pwdata[6:4]}]) begin
                err_set = 1'b1;
              end else begin
                next_state = EDQ_S_START;
              end
            end
            EDQ_OP_APPEND: begin
              if (misaligned(desc_addr) || misaligned(next_ptr)) begin
                err_set = 1'b1;
              end else begin
                next_state = EDQ_S_APPEND;
              end
            end
            EDQ_OP_POLL: begin
              if (misaligned(desc_addr) || ch_bad(pwdata[6:4])) begin
                err_set = 1'b1;
              end else begin
                next_state = EDQ_S_POLL;
              end
            end
            default: err_set = 1'b1;
          endcase
        end
      end
      EDQ_S_BUILD: begin
        mx_start = 1'b1;
        mreq = {1'b1, desc_addr + {28'h0, word, 2'b00}, words[word]};
        if (mx_done && word == 2'h3) begin
          next_state = EDQ_S_IDLE;
        end
      end
      EDQ_S_START: begin
        hdp_wr_in = 1'b1;
        hdp_req = {cmd_rx, cmd_ch, desc_addr};
        next_state = EDQ_S_IDLE;
      end
      EDQ_S_APPEND: begin
        mx_start = 1'b1;
        mreq = {1'b1, desc_addr, next_ptr};
        if (mx_done) begin
          next_state = EDQ_S_IDLE;
        end
      end
      EDQ_S_POLL: begin
        mx_start = 1'b1;
        mreq = {1'b0, desc_addr + `EDQ_WORD_FLGLEN, 32'h00000000};
        if (mx_done) begin
          next_state = EDQ_S_POLLCHK;
        end
      end
      EDQ_S_POLLCHK: begin
        // queue end seen, retire or restart
        if (mx_rdata[`EDQ_FLG_QEND] && mx_rdata[`EDQ_FLG_LAST] && !mx_rdata[`EDQ_FLG_ENGINE_OWNS_FLAG]) begin
          clr = 1'b1;
          if (restart_ptr != 32'h00000000) begin
            hdp_wr_in = 1'b1;
            hdp_req = {cmd_rx, cmd_ch, restart_ptr};
            restart_take = 1'b1;
          end
        end
        next_state = EDQ_S_IDLE;
      end
      default: next_state = EDQ_S_IDLE;
    endcase
  end

  edq_mem_xfer u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .start(mx_start),
    .req(mreq),
    .mem_valid(mem_valid),
    .mem_out(mem_req),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(mx_done),
    .rdata(mx_rdata)
  );

  edq_hdp_if u_hdp (
    .clk(clk),
    .rst_n(rst_n),
    .wr_in(hdp_wr_in),
    .req(hdp_req),
    .clr(clr),
    .clr_idx({cmd_rx, cmd_ch}),
    .hdp_wr(hdp_wr),
    .hdp(hdp),
    .active(active)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_init_zero: assert property (hdp_wr && !init_done |-> hdp.ptr == 32'h00000000)
    else $error("nonzero head pointer during init");
  a_init_bound: assert property (!init_done |-> ##[0:20] init_done)
    else $error("head pointer clearing did not finish");
  a_enable_gate: assert property ((tx_enable || rx_enable) |-> init_done)
    else $error("enable before head pointers cleared");
  a_desc_align: assert property (mem_valid |-> mem_req.addr[1:0] == 2'b00)
    else $error("misaligned descriptor access");
  a_engine_owns_flag_first: assert property (mem_valid && mem_req.we && state == EDQ_S_BUILD && word == 2'h3 &&
    mem_req.wdata[`EDQ_FLG_ENGINE_OWNS_FLAG] |-> mem_req.wdata[`EDQ_FLG_FIRST])
    else $error("engine_owns_flag flag without first fragment flag");
  a_append_next: assert property (state == EDQ_S_APPEND && mem_valid |->
    mem_req.we && mem_req.addr == desc_addr && mem_req.wdata == next_ptr)
    else $error("append wrote other than next pointer word");
  a_poll_flags: assert property (state == EDQ_S_POLL && mem_valid |->
    !mem_req.we && mem_req.addr == desc_addr + `EDQ_WORD_FLGLEN)
    else $error("poll did not read flags word");
  a_start_write: assert property (state == EDQ_S_START |=>
    hdp_wr && hdp.ptr == desc_addr && hdp.ch == cmd_ch && hdp.rx == cmd_rx)
    else $error("start did not write head pointer");
  a_queue_idle: assert property (clr |=> ##1 !active[$past({cmd_rx, cmd_ch}, 2)] ||
    $past(hdp_wr_in, 2))
    else $error("queue not idle after queue end");
  a_busy_refuse: assert property (apb_wr && paddr == `EDQ_OFF_CMD && state != EDQ_S_IDLE |=> err)
    else $error("command while busy not flagged");

  c_build: cover property (state == EDQ_S_BUILD && mx_done && word == 2'h3);
  c_start: cover property (state == EDQ_S_START);
  c_append: cover property (state == EDQ_S_APPEND && mx_done);
  c_restart: cover property (restart_take);
endmodule : edq_host

// File: dv/edq_dev_model.sv
// device model: descriptor memory and head pointer registers
module edq_dev_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_valid,
  input edq_pkg::edq_mreq_t mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic hdp_wr,
  input edq_pkg::edq_hdp_t hdp
);
  timeunit 1ns;
  timeprecision 1ps;
  import edq_pkg::*;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] head [16];
  int wt;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction : rd
  task automatic run_list(input logic [31:0] p);
    logic [31:0] s;
    logic [31:0] f;
    for (int n = 0; n < 16; n++) begin
      f = rd(p + 32'hC);
      // stop on a zero pointer or an unowned packet
      if (p == 32'h0 || !f[31] || !f[29]) break;
      s = p;
      // walk the fragments up to the last one
      for (int k = 0; k < 16 && !f[30] && rd(p) != 32'h0; k++) begin
        p = rd(p);
        f = rd(p + 32'hC);
      end
      // mark queue end on a null next pointer and go idle
      if (rd(p) == 32'h0) mem[p + 32'hC] = f | 32'h10000000;
      // clear the owner flag in the starting flags word; flags words change, never a next pointer
      mem[s + 32'hC] = rd(s + 32'hC) & 32'hDFFFFFFF;
      p = rd(p);
    end
  endtask : run_list
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5A5A5A5A;
      wt <= 0;
    end else if (mem_valid && mem_ack) begin
      if (mem_req.we) mem[mem_req.addr] = mem_req.wdata;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wt <= $urandom_range(0, 3);
    end else if (mem_valid && wt > 0) begin
      wt <= wt - 1;
    end else if (mem_valid) begin
      mem_ack <= 1'b1;
      mem_rdata <= rd(mem_req.addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  always @(posedge clk) begin
    if (rst_n && hdp_wr) begin
      head[{hdp.rx, hdp.ch}] = hdp.ptr;
      // a head write starts the list in either direction
      run_list(hdp.ptr);
    end
  end
endmodule : edq_dev_model

// File: dv/ethernet_descriptor_queue_dma_test.sv
// self-checking bench for the descriptor queue host controller
`include "edq_defines.svh"
module ethernet_descriptor_queue_dma_test;
  timeunit 1ns;
  timeprecision 1ps;
  import edq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_valid;
  edq_mreq_t mem_req;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic hdp_wr;
  edq_hdp_t hdp;
  logic tx_enable;
  logic rx_enable;
  int num_errors = 0;
  int tests_run = 0;
  edq_hdp_t exp_q[$];
  logic [31:0] rq;
  logic re;
  logic [3:0] q;
  logic [15:0] l0, l1, l2;
  logic [31:0] ew [4];
  always #5 clk = ~clk;
  edq_host #(.CHANNELS(8)) edq_host_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .hdp_wr(hdp_wr), .hdp(hdp),
    .tx_enable(tx_enable), .rx_enable(rx_enable));
  edq_dev_model edq_dev_model_inst (.clk(clk), .rst_n(rst_n), .mem_valid(mem_valid), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .hdp_wr(hdp_wr), .hdp(hdp));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [2:0] op, input logic [3:0] qq, input logic [31:0] a);
    apb(1'b1, `EDQ_OFF_ADDR, a);
    apb(1'b1, `EDQ_OFF_CMD, {25'h0, qq[2:0], qq[3], op});
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, `EDQ_OFF_STATUS, 32'h0);
      if (rq[0] === 1'b0) break;
    end
  endtask : cmd
  task automatic errchk(input logic e);
    apb(1'b0, `EDQ_OFF_STATUS, 32'h0);
    check(rq[2], e);
    apb(1'b1, `EDQ_OFF_STATUS, 32'h4);
  endtask : errchk
  task automatic build(input logic [31:0] a, input logic [31:0] nx, input logic [31:0] bf,
    input logic [31:0] ol, input logic [31:0] fl);
    apb(1'b1, `EDQ_OFF_NEXT, nx);
    apb(1'b1, `EDQ_OFF_BUF, bf);
    apb(1'b1, `EDQ_OFF_OFFLEN, ol);
    apb(1'b1, `EDQ_OFF_FLGLEN, fl);
    cmd(3'd1, 4'h0, a);
  endtask : build
  task automatic start(input logic [3:0] qq, input logic [31:0] a);
    exp_q.push_back('{rx: qq[3], ch: qq[2:0], ptr: a});
    cmd(3'd2, qq, a);
  endtask : start
  always @(posedge clk) begin
    if (rst_n === 1'b1 && hdp_wr === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check(hdp, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out;
  end
  initial begin
    void'($urandom(69366));
    for (int i = 0; i < 16; i++) exp_q.push_back('{rx: i[3], ch: i[2:0], ptr: 32'h0});
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, `EDQ_OFF_ENABLE, 32'h3);
    check({tx_enable, rx_enable}, 2'b00);
    apb(1'b1, `EDQ_OFF_CMD, 32'h2);
    for (int n = 0; n < 40 && rq[1] !== 1'b1; n++) apb(1'b0, `EDQ_OFF_STATUS, 32'h0);
    @(posedge clk);
    check(exp_q.size(), 0);
    errchk(1'b1);
    apb(1'b1, `EDQ_OFF_ENABLE, 32'h3);
    @(posedge clk);
    check({tx_enable, rx_enable}, 2'b11);
    apb(1'b0, 8'h40, 32'h0);
    check(re, 1'b1);
    q = 4'($urandom_range(0, 15));
    l0 = 16'($urandom_range(1, 1500));
    l1 = 16'($urandom_range(1, 1500));
    l2 = 16'($urandom_range(1, 1500));
    ew = '{32'h110, $urandom, {16'h0004, l0}, {16'hA000, l0 + l1 + l2}};
    build(32'h100, ew[0], ew[1], ew[2], ew[3]);
    for (int k = 0; k < 4; k++) check(edq_dev_model_inst.rd(32'(32'h100 + 4 * k)), ew[k]);
    build(32'h110, 32'h120, $urandom, {16'h0, l1}, 32'h0);
    build(32'h120, 32'h0, $urandom, {16'h0, l2}, 32'h40000000);
    build(32'h200, 32'h0, $urandom, {16'h0, l0}, {16'hE000, l0});
    errchk(1'b0);
    build(32'h300, 32'h0, 32'h0, 32'h0, 32'h20000000);
    errchk(1'b1);
    build(32'h302, 32'h0, 32'h0, 32'h0, 32'hE0000000);
    errchk(1'b1);
    check(edq_dev_model_inst.rd(32'h300 + 32'hC), 32'h0);
    start(q, 32'h100);
    errchk(1'b0);
    apb(1'b0, `EDQ_OFF_ACTIVE, 32'h0);
    check(rq[q], 1'b1);
    cmd(3'd2, q, 32'h100);
    errchk(1'b1);
    apb(1'b1, `EDQ_OFF_NEXT, 32'h200);
    cmd(3'd3, q, 32'h120);
    check(edq_dev_model_inst.rd(32'h120), 32'h200);
    cmd(3'd3, q, 32'h121);
    errchk(1'b1);
    cmd(3'd4, q, 32'h100);
    apb(1'b0, `EDQ_OFF_STATUS, 32'h0);
    check(rq[31:16], 16'h8000);
    apb(1'b0, `EDQ_OFF_ACTIVE, 32'h0);
    check(rq[q], 1'b1);
    apb(1'b1, `EDQ_OFF_RESTART, 32'h200);
    exp_q.push_back('{rx: q[3], ch: q[2:0], ptr: 32'h200});
    cmd(3'd4, q, 32'h120);
    apb(1'b0, `EDQ_OFF_STATUS, 32'h0);
    check(rq[31:16], 16'h5000);
    apb(1'b0, `EDQ_OFF_RESTART, 32'h0);
    check(rq, 32'h0);
    apb(1'b0, `EDQ_OFF_ACTIVE, 32'h0);
    check(rq[q], 1'b1);
    cmd(3'd4, q, 32'h200);
    apb(1'b0, `EDQ_OFF_ACTIVE, 32'h0);
    check(rq[q], 1'b0);
    start(q, 32'h200);
    errchk(1'b0);
    q = q ^ 4'h8;
    start(q, 32'h100);
    apb(1'b0, `EDQ_OFF_ACTIVE, 32'h0);
    check(rq[q], 1'b1);
    cmd(3'd5, q, 32'h0);
    errchk(1'b1);
    repeat (4) @(posedge clk);
    check(exp_q.size(), 0);
    close_out;
  end
endmodule : ethernet_descriptor_queue_dma_test
